// ### pss_ext_clock.sv
`timescale 1ns/1ps
module pss_ext_clock (
    // system
    input  wire logic clock,
    input  wire logic reset,
    // control
    input  wire logic enable,
    // clock out
    output logic      ext_input_clock
);

    logic [7:0] div_reg;
    logic [7:0] div_next;
    logic       clk_reg;
    logic       clk_next;

    // divide down, parked low while disabled
    always_comb begin
        div_next = div_reg;
        clk_next = clk_reg;
        if (!enable) begin
            div_next = 8'h00;
            clk_next = 1'b0;
        end else if (div_reg == 8'(pss_pkg::EXT_CLK_DIV - 1)) begin
            div_next = 8'h00;
            clk_next = ~clk_reg;
        end else begin
            div_next = div_reg + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            div_reg <= 8'h00;
            clk_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            clk_reg <= clk_next;
        end
    end

    assign ext_input_clock = clk_reg;

endmodule

// ### pss_pkg.sv
package pss_pkg;

    // ------------------------------------------------------------
    // timing figures and derived cycle counts
    // ------------------------------------------------------------
    localparam int CLK_MHZ           = 125;
    localparam int RAIL_GAP_US       = 10;   // longest gap between rails
    localparam int CORE_IO_GAP_US    = 5;    // preferred least core-to-io gap
    localparam int RESET_HOLD_MS     = 1;
    localparam int INIT_EXT_CLOCKS   = 150000;
    localparam int PLL_LOCK_MS       = 1;
    localparam int OFF_TIME_MS       = 100;
    localparam int RAIL_GAP_CYC      = RAIL_GAP_US * CLK_MHZ;
    localparam int CORE_IO_GAP_CYC   = CORE_IO_GAP_US * CLK_MHZ;
    localparam int RESET_HOLD_CYC    = RESET_HOLD_MS * 1000 * CLK_MHZ;
    localparam int PLL_LOCK_CYC      = PLL_LOCK_MS * 1000 * CLK_MHZ;
    localparam int OFF_TIME_CYC      = OFF_TIME_MS * 1000 * CLK_MHZ;
    localparam int EXT_CLK_DIV       = 4;    // ext clock = clock / (2 * div)
    localparam int INIT_CYC          = INIT_EXT_CLOCKS * 2 * EXT_CLK_DIV;
    localparam int CNT_W             = 32;

    // ------------------------------------------------------------
    // sensor register and field
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_REG_ADDR    = 16'h301a;
    localparam int          STREAM_BIT_POS   = 2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic pll;
        logic analog_pix;   // analog and pixel_array_supply together
        logic core;
        logic io;
        logic serial_link;  // serial_link_supply, optional
    } pss_rails_s;

    typedef struct packed {
        logic [15:0] addr;
        logic        set;   // 1 sets stream_enable_bit, 0 clears it
    } pss_wr_s;

endpackage

// ### pss_sensor_model.sv
`timescale 1ns/1ps
module pss_sensor_model #(
    parameter int INIT_EXT = 4
) (
    // system
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        slow,
    // pins from the sequencer
    input  wire logic        ext_input_clock,
    input  wire logic        hard_reset_n,
    input  wire logic        wr_valid,
    input  pss_pkg::pss_wr_s wr_data,
    input  wire logic        config_start,
    // answers
    output logic             wr_done,
    output logic             config_done,
    output logic             standby_reached,
    output logic             fault
);
    int   init_cnt;
    int   wait_cnt;
    int   dly;
    logic clk_q, cfg_pend, cfg_ok, stream_bit, busy;

    // answer delay, and whether any answer is owed
    assign dly  = slow ? 8 : 1;
    assign busy = cfg_pend || (wr_valid && !wr_done) || (!stream_bit && !standby_reached);

    // sensor: reset, init count, configuration, control bit, standby
    always_ff @(posedge clock) begin
        clk_q       <= ext_input_clock;
        wr_done     <= 1'b0;
        config_done <= 1'b0;
        if (reset || !hard_reset_n) begin
            {init_cnt, wait_cnt} <= '0;
            {cfg_pend, cfg_ok, stream_bit} <= '0;
            standby_reached <= 1'b1;
            fault <= !reset && (fault || wr_valid || config_start);
        end else begin
            if (ext_input_clock && !clk_q && init_cnt < INIT_EXT)
                init_cnt <= init_cnt + 1;
            if (config_start) begin
                cfg_pend <= 1'b1;
                fault    <= fault || init_cnt < INIT_EXT;
            end
            wait_cnt <= (busy && wait_cnt < dly) ? wait_cnt + 1 : 0;
            if (busy && wait_cnt >= dly) begin
                if (cfg_pend) begin
                    config_done <= 1'b1;
                    cfg_pend    <= 1'b0;
                    cfg_ok      <= 1'b1;
                end else if (wr_valid && !wr_done) begin
                    wr_done         <= 1'b1;
                    stream_bit      <= wr_data.set;
                    standby_reached <= 1'b0;
                    fault <= fault || (wr_data.set && !cfg_ok);
                end else begin
                    standby_reached <= 1'b1;
                end
            end
        end
    end
endmodule

// ### pss_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// RULE_01: pll supply rises first, never later
// RULE_02: core then io, each within 10 us
// RULE_03: at least 5 us core to io
// RULE_04: input clock starts after rails stable
// RULE_05: hold hard reset low at least 1 ms
// RULE_06: reset time counts from rails settled
// RULE_07: wait 150,000 input clocks after reset release
// RULE_08: configure sensor registers before streaming
// RULE_09: wait 1 ms for pll lock
// RULE_10: write stream bit one at 0x301a last
// RULE_11: power-down starts by clearing stream bit
// RULE_12: sensor idles at row or frame end
// RULE_13: rails off serial, io, core, analog, pll
// RULE_14: rails stay off at least 100 ms
// RULE_15: no writes during reset or initialization
module pss_sequencer #(
    parameter int RESET_HOLD_CYC = pss_pkg::RESET_HOLD_CYC,
    parameter int INIT_CYC       = pss_pkg::INIT_CYC,
    parameter int PLL_LOCK_CYC   = pss_pkg::PLL_LOCK_CYC,
    parameter int OFF_TIME_CYC   = pss_pkg::OFF_TIME_CYC
) (
    // system
    input  wire logic            clock,
    input  wire logic            reset,
    // user requests
    input  wire logic            power_up_req,
    input  wire logic            power_down_req,
    input  wire logic            use_serial_link,
    // rails and pins
    output pss_pkg::pss_rails_s  rails_en,
    output logic                 ext_input_clock,
    output logic                 hard_reset_n,
    // register write port to serial engine
    output logic                 wr_valid,
    output pss_pkg::pss_wr_s     wr_data,
    input  wire logic            wr_done,
    input  wire logic            config_done,
    output logic                 config_start,
    input  wire logic            standby_reached,
    // status
    output logic                 streaming,
    output logic                 ready_for_up
);

    typedef enum logic [3:0] {
        PSS_OFF, PSS_PLL, PSS_ANALOG, PSS_CORE, PSS_IO, PSS_SERIAL, PSS_RESET,
        PSS_INIT, PSS_CONFIG, PSS_LOCK, PSS_STREAM_WR, PSS_STREAMING,
        PSS_STOP_WR, PSS_STANDBY, PSS_DOWN
    } pss_state_e;

    // --------------------------------------------------------------
    // synchronisers for inputs from outside the domain
    // --------------------------------------------------------------
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;

    always_ff @(posedge clock) begin
        if (reset) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
        end else begin
            sync1_reg <= {power_up_req, power_down_req, use_serial_link, standby_reached};
            sync2_reg <= sync1_reg;
        end
    end

    logic up_s;
    logic down_s;
    logic slvs_s;
    logic stby_s;
    assign up_s   = sync2_reg[3];
    assign down_s = sync2_reg[2];
    assign slvs_s = sync2_reg[1];
    assign stby_s = sync2_reg[0];

    // --------------------------------------------------------------
    // state and outputs
    // --------------------------------------------------------------
    pss_state_e          state_reg;
    pss_state_e          state_next;
    logic [31:0]         cnt_reg;
    logic [31:0]         cnt_next;
    pss_pkg::pss_rails_s rails_reg;
    pss_pkg::pss_rails_s rails_next;
    logic                clk_en_reg;
    logic                clk_en_next;
    logic                rst_n_reg;
    logic                rst_n_next;
    logic                wr_valid_reg;
    logic                wr_valid_next;
    logic                wr_set_reg;
    logic                wr_set_next;
    logic                cfg_reg;
    logic                cfg_next;
    logic                stream_reg;
    logic                stream_next;
    logic                ready_reg;
    logic                ready_next;

    function automatic logic expired(input logic [31:0] c, input int limit);
        expired = (c >= 32'(limit - 1));
    endfunction

    // rail stepping, gap timing, reset, init and stream control
    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg + 32'h1;
        rails_next    = rails_reg;
        clk_en_next   = clk_en_reg;
        rst_n_next    = rst_n_reg;
        wr_valid_next = wr_valid_reg;
        wr_set_next   = wr_set_reg;
        cfg_next      = 1'b0;
        stream_next   = stream_reg;
        ready_next    = ready_reg;
        case (state_reg)
            PSS_OFF: begin
                // off time counted here after any power-down
                if (!expired(cnt_reg, OFF_TIME_CYC)) begin // RULE_14
                    ready_next = 1'b0;
                end else begin
                    ready_next = 1'b1;
                    cnt_next   = cnt_reg;
                    if (up_s) begin
                        ready_next     = 1'b0;
                        rails_next.pll = 1'b1; // RULE_01
                        cnt_next       = 32'h0;
                        state_next     = PSS_PLL;
                    end
                end
            end
            PSS_PLL: begin
                rails_next.analog_pix = 1'b1; // RULE_01
                cnt_next              = 32'h0;
                state_next            = PSS_ANALOG;
            end
            PSS_ANALOG: begin
                rails_next.core = 1'b1; // RULE_02
                cnt_next        = 32'h0;
                state_next      = PSS_CORE;
            end
            PSS_CORE: begin
                // io after 5 us, well inside the 10 us limit
                if (expired(cnt_reg, pss_pkg::CORE_IO_GAP_CYC)) begin // RULE_03
                    rails_next.io = 1'b1; // RULE_02
                    cnt_next      = 32'h0;
                    state_next    = PSS_IO;
                end
            end
            PSS_IO: begin
                rails_next.serial_link = slvs_s;
                cnt_next               = 32'h0;
                state_next             = PSS_SERIAL;
            end
            PSS_SERIAL: begin
                // let the last rail settle, then start the clock
                if (expired(cnt_reg, pss_pkg::RAIL_GAP_CYC)) begin
                    clk_en_next = 1'b1; // RULE_04
                    cnt_next    = 32'h0;
                    state_next  = PSS_RESET;
                end
            end
            PSS_RESET: begin
                // reset held low from rails settled and clock running
                if (expired(cnt_reg, RESET_HOLD_CYC)) begin // RULE_05 RULE_06
                    rst_n_next = 1'b1;
                    cnt_next   = 32'h0;
                    state_next = PSS_INIT;
                end
            end
            PSS_INIT: begin
                if (expired(cnt_reg, INIT_CYC)) begin // RULE_07 RULE_15
                    cfg_next   = 1'b1; // RULE_08
                    state_next = PSS_CONFIG;
                end
            end
            PSS_CONFIG: begin
                cnt_next = 32'h0;
                if (config_done) begin
                    state_next = PSS_LOCK;
                end
            end
            PSS_LOCK: begin
                if (expired(cnt_reg, PLL_LOCK_CYC)) begin // RULE_09
                    wr_valid_next = 1'b1;
                    wr_set_next   = 1'b1; // RULE_10
                    state_next    = PSS_STREAM_WR;
                end
            end
            PSS_STREAM_WR: begin
                if (wr_done) begin
                    wr_valid_next = 1'b0;
                    stream_next   = 1'b1;
                    state_next    = PSS_STREAMING;
                end
            end
            PSS_STREAMING: begin
                if (down_s) begin
                    wr_valid_next = 1'b1;
                    wr_set_next   = 1'b0; // RULE_11
                    state_next    = PSS_STOP_WR;
                end
            end
            PSS_STOP_WR: begin
                if (wr_done) begin
                    wr_valid_next = 1'b0;
                    stream_next   = 1'b0;
                    state_next    = PSS_STANDBY;
                end
            end
            PSS_STANDBY: begin
                // sensor finishes its row or frame first
                cnt_next = 32'h0;
                if (stby_s) begin // RULE_12
                    clk_en_next = 1'b0;
                    rst_n_next  = 1'b0;
                    state_next  = PSS_DOWN;
                end
            end
            PSS_DOWN: begin
                // drop one rail per cycle, last raised first
                cnt_next = 32'h0;
                if (rails_reg.serial_link) begin // RULE_13
                    rails_next.serial_link = 1'b0;
                end else if (rails_reg.io) begin
                    rails_next.io = 1'b0;
                end else if (rails_reg.core) begin
                    rails_next.core = 1'b0;
                end else if (rails_reg.analog_pix) begin
                    rails_next.analog_pix = 1'b0;
                end else begin
                    rails_next.pll = 1'b0;
                    state_next     = PSS_OFF;
                end
            end
            default: begin
                state_next = PSS_OFF;
            end
        endcase
    end

    // registers, off state timer starts from zero at reset
    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg    <= PSS_OFF;
            cnt_reg      <= 32'h0;
            rails_reg    <= '0;
            clk_en_reg   <= 1'b0;
            rst_n_reg    <= 1'b0;
            wr_valid_reg <= 1'b0;
            wr_set_reg   <= 1'b0;
            cfg_reg      <= 1'b0;
            stream_reg   <= 1'b0;
            ready_reg    <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            rails_reg    <= rails_next;
            clk_en_reg   <= clk_en_next;
            rst_n_reg    <= rst_n_next;
            wr_valid_reg <= wr_valid_next;
            wr_set_reg   <= wr_set_next;
            cfg_reg      <= cfg_next;
            stream_reg   <= stream_next;
            ready_reg    <= ready_next;
        end
    end

    // --------------------------------------------------------------
    // input clock generator
    // --------------------------------------------------------------
    pss_ext_clock u_ext_clock (
        .clock           (clock),
        .reset           (reset),
        .enable          (clk_en_reg),
        .ext_input_clock (ext_input_clock)
    );

    assign rails_en      = rails_reg;
    assign hard_reset_n  = rst_n_reg;
    assign wr_valid      = wr_valid_reg;
    assign wr_data.addr  = pss_pkg::CTRL_REG_ADDR;
    assign wr_data.set   = wr_set_reg;
    assign config_start  = cfg_reg;
    assign streaming     = stream_reg;
    assign ready_for_up  = ready_reg;

endmodule

// ### pss_sequencer_assertions.sv
`timescale 1ns/1ps
module pss_sequencer_assertions #(
    parameter int RESET_HOLD_CYC = 20,
    parameter int INIT_CYC       = 40,
    parameter int PLL_LOCK_CYC   = 20,
    parameter int OFF_TIME_CYC   = 30
) (
    // system
    input  wire logic           clock,
    input  wire logic           reset,
    // rails and pins
    input  pss_pkg::pss_rails_s rails_en,
    input  wire logic           ext_input_clock,
    input  wire logic           hard_reset_n,
    // write port and status
    input  wire logic           wr_valid,
    input  pss_pkg::pss_wr_s    wr_data,
    input  wire logic           wr_done,
    input  wire logic           config_done,
    input  wire logic           config_start,
    input  wire logic           standby_reached,
    input  wire logic           streaming
);
    localparam int GAP_MAX = pss_pkg::RAIL_GAP_CYC;
    localparam int RST_MIN = pss_pkg::RAIL_GAP_CYC + RESET_HOLD_CYC - 2;
    int io_gap, rst_cnt, init_cnt, lock_cnt, off_cnt, pa_gap, ac_gap;

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // ----------------------------------------
    // cycle counters for the timing checks
    // ----------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            {io_gap, rst_cnt, init_cnt, lock_cnt, off_cnt, pa_gap, ac_gap} <= '0;
        end else begin
            // cycles spent waiting for the next rail to rise, in and after hard reset, since config, and with pll off
            pa_gap   <= (rails_en.pll && !rails_en.analog_pix) ? pa_gap + 1 : 0;
            ac_gap   <= (rails_en.analog_pix && !rails_en.core) ? ac_gap + 1 : 0;
            io_gap   <= rails_en.core ? io_gap + int'(!rails_en.io) : 0;
            rst_cnt  <= (rails_en.io && !hard_reset_n) ? rst_cnt + 1 : 0;
            init_cnt <= hard_reset_n ? init_cnt + 1 : 0;
            lock_cnt <= (config_done || config_start) ? 0 : lock_cnt + 1;
            off_cnt  <= rails_en.pll ? 0 : off_cnt + 1;
        end
    end

    // ----------------------------------------
    // sequences and checks
    // ----------------------------------------
    sequence s_pll_up;
        $rose(rails_en.pll);
    endsequence
    sequence s_stop_done;
        wr_valid && wr_done && !wr_data.set;
    endsequence
    sequence s_awake2;
        (hard_reset_n && rails_en.io) [*2];
    endsequence

    AST_RAIL_NEST: assert property (
        (!rails_en.serial_link || rails_en.io) && (!rails_en.io || rails_en.core)
        && (!rails_en.core || rails_en.analog_pix) && (!rails_en.analog_pix || rails_en.pll))
        else $error("rail order broken");
    AST_UP_GAPS: assert property (
        ($rose(rails_en.analog_pix) |-> pa_gap <= GAP_MAX)
        and ($rose(rails_en.core) |-> ac_gap <= GAP_MAX))
        else $error("rail gap too long");
    AST_IO_GAP: assert property ($rose(rails_en.io) |->
        io_gap >= pss_pkg::CORE_IO_GAP_CYC && io_gap <= GAP_MAX)
        else $error("core to io gap wrong");
    AST_CLK_RAILS: assert property (ext_input_clock |-> rails_en.io)
        else $error("clock without rails");
    AST_RST_HOLD: assert property ($rose(hard_reset_n) |-> rst_cnt >= RST_MIN)
        else $error("hard reset too short");
    AST_INIT_WAIT: assert property ($rose(config_start) |-> init_cnt >= INIT_CYC - 2)
        else $error("init count not waited");
    AST_NO_EARLY_WR: assert property ((wr_valid || config_start) |-> hard_reset_n)
        else $error("access during hard reset");
    AST_LOCK_WAIT: assert property (
        $rose(wr_valid) && wr_data.set |-> lock_cnt >= PLL_LOCK_CYC - 2)
        else $error("lock time not waited");
    AST_STREAM_ADDR: assert property (wr_valid |-> wr_data.addr == pss_pkg::CTRL_REG_ADDR)
        else $error("write address wrong");
    AST_STREAM_ON: assert property ($rose(streaming) |-> $past(wr_done && wr_data.set))
        else $error("streaming without write");
    AST_STOP_FIRST: assert property (s_stop_done ##1 !standby_reached |-> s_awake2)
        else $error("powered down before standby");
    AST_DOWN_STOPPED: assert property (
        $fell(rails_en.io) |-> !streaming && !hard_reset_n)
        else $error("rails off while streaming");
    AST_OFF_TIME: assert property (s_pll_up |-> off_cnt >= OFF_TIME_CYC - 1)
        else $error("off time too short");
endmodule

bind pss_sequencer pss_sequencer_assertions #(
    .RESET_HOLD_CYC(RESET_HOLD_CYC), .INIT_CYC(INIT_CYC),
    .PLL_LOCK_CYC(PLL_LOCK_CYC), .OFF_TIME_CYC(OFF_TIME_CYC)
) chk_u (
    .clock(clock), .reset(reset), .rails_en(rails_en), .ext_input_clock(ext_input_clock),
    .hard_reset_n(hard_reset_n), .wr_valid(wr_valid), .wr_data(wr_data), .wr_done(wr_done),
    .config_done(config_done), .config_start(config_start),
    .standby_reached(standby_reached), .streaming(streaming)
);

// ### tb.sv
`timescale 1ns/1ps
module tb;
    localparam int OFF = 30;
    logic                clock, reset, slow, fault;
    logic                power_up_req, power_down_req, use_serial_link;
    pss_pkg::pss_rails_s rails_en;
    pss_pkg::pss_wr_s    wr_data;
    logic                ext_input_clock, hard_reset_n, wr_valid, wr_done;
    logic                config_done, config_start, standby_reached, streaming, ready_for_up;
    int                  n_fail, n_tests;

    pss_sequencer #(.RESET_HOLD_CYC(20), .INIT_CYC(40), .PLL_LOCK_CYC(20), .OFF_TIME_CYC(OFF))
    dut_u (.clock(clock), .reset(reset), .power_up_req(power_up_req),
        .power_down_req(power_down_req), .use_serial_link(use_serial_link),
        .rails_en(rails_en), .ext_input_clock(ext_input_clock), .hard_reset_n(hard_reset_n),
        .wr_valid(wr_valid), .wr_data(wr_data), .wr_done(wr_done), .config_done(config_done),
        .config_start(config_start), .standby_reached(standby_reached),
        .streaming(streaming), .ready_for_up(ready_for_up));
    pss_sensor_model #(.INIT_EXT(4)) sensor_u (.clock(clock), .reset(reset), .slow(slow),
        .ext_input_clock(ext_input_clock), .hard_reset_n(hard_reset_n), .wr_valid(wr_valid),
        .wr_data(wr_data), .config_start(config_start), .wr_done(wr_done),
        .config_done(config_done), .standby_reached(standby_reached), .fault(fault));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic step(int n = 1);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        if (n_fail == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    function automatic logic cond(int sel);
        case (sel)
            0: return streaming;
            1: return ready_for_up;
            2: return rails_en.pll;
            3: return rails_en.io;
            4: return wr_valid;
            5: return !rails_en.io;
            default: return !rails_en.pll;
        endcase
    endfunction
    task automatic wait_on(int sel, int lim, output int n);
        for (n = 0; cond(sel) !== 1'b1; n++) begin
            if (n == lim) begin
                n_fail++;
                conclude();
            end
            step();
        end
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_after_reset();
        int n;
        power_down_req = 1'b1;
        check("rails_reset", rails_en, 0);
        check("reset_pin", hard_reset_n, 0);
        wait_on(1, 200, n);
        check("off_time", n >= OFF - 1, 1);
        check("down_refused", rails_en, 0);
        power_down_req = 1'b0;
    endtask
    task automatic t_power_up(logic serial, logic slw);
        int   n;
        logic q;
        use_serial_link = serial;
        slow = slw;
        power_up_req = 1'b1;
        wait_on(2, 200, n);
        check("pll_only", rails_en, 5'b10000);
        step();
        check("analog_on", rails_en, 5'b11000);
        step();
        check("core_on", rails_en, 5'b11100);
        wait_on(3, 2000, n);
        check("core_io_gap", n >= pss_pkg::CORE_IO_GAP_CYC && n <= pss_pkg::RAIL_GAP_CYC, 1);
        check("clock_idle", ext_input_clock, 0);
        check("reset_held", hard_reset_n, 0);
        wait_on(0, 4000, n);
        check("rails_up", rails_en, {4'hf, serial});
        check("reset_free", hard_reset_n, 1);
        // input clock must toggle every EXT_CLK_DIV cycles while up
        n = 0;
        q = ext_input_clock;
        repeat (4 * pss_pkg::EXT_CLK_DIV) begin
            step();
            n += int'(ext_input_clock != q);
            q = ext_input_clock;
        end
        check("clock_running", n, 4);
        power_up_req = 1'b0;
    endtask
    task automatic t_power_down();
        int n;
        power_down_req = 1'b1;
        wait_on(4, 50, n);
        check("stop_write", wr_data, {pss_pkg::CTRL_REG_ADDR, 1'b0});
        check("io_held", rails_en.io, 1);
        wait_on(5, 200, n);
        check("serial_first", rails_en.serial_link, 0);
        check("core_after_io", rails_en.core, 1);
        check("stream_off", streaming, 0);
        wait_on(6, 20, n);
        check("all_off", rails_en, 0);
        check("clock_off", ext_input_clock, 0);
        check("reset_low", hard_reset_n, 0);
        power_down_req = 1'b0;
    endtask

    // clock source
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // main sequence: two cycles, slow then prompt sensor
    initial begin
        n_fail = 0;
        n_tests = 0;
        {reset, slow, power_up_req, power_down_req, use_serial_link} = 5'h10;
        step(4);
        reset = 1'b0;
        t_after_reset();
        for (int s = 0; s < 2; s++) begin
            t_power_up(s[0], !s[0]);
            t_power_down();
        end
        check("sensor_fault", fault, 0);
        conclude();
    end
endmodule
